// ==== logic/fault_io_map.vh ====
// Register offsets, field positions and reset values of the fault/test block
`ifndef FAULT_IO_MAP_VH
`define FAULT_IO_MAP_VH

// ----------------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------------
`define ADDR_CTRL       8'h00
`define ADDR_STATUS     8'h04
`define ADDR_FLT_CODE   8'h08
`define ADDR_FLT_DESC   8'h0c
`define ADDR_TEST_IN    8'h10
`define ADDR_TEST_OUT   8'h14
`define ADDR_POLARITY   8'h18
`define ADDR_RX_DATA    8'h1c
`define ADDR_IRQ_STAT   8'h20
`define ADDR_IRQ_CLR    8'h24
`define ADDR_IRQ_EN     8'h28

// ----------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------
`define CTRL_TEST_BIT   0
`define CTRL_CLEAR_BIT  1
`define ST_FAULT_BIT    0
`define ST_RUN_BIT      1
`define ST_TEST_BIT     2
`define ST_TEST_ACT_BIT 3
`define OUT_GEN_LSB     0
`define OUT_SPARE_LSB   4
`define OUT_STB_BIT     6
`define OUT_RCP_LSB     8
`define IN_GEN_LSB      0
`define IN_TRIG1_BIT    4
`define IN_TRIG2_BIT    5
`define IN_STB_BIT      6
`define IN_RCP_LSB      8
`define RX_FULL_BIT     8
`define IRQ_FAULT_BIT   0
`define IRQ_RX0_BIT     1
`define IRQ_RX1_BIT     2

// ----------------------------------------------------------------------
// Reset values and fixed codes
// ----------------------------------------------------------------------
`define CTRL_RESET      1'b0
`define TEST_OUT_RESET  13'h0000
`define POLARITY_RESET  13'h1fff
`define IRQ_EN_RESET    3'h0
`define ORDINARY_CODE   16'h0000
`define TEST_STR_LEN    4'h8
`define HTRANS_NONSEQ   2'h2
`define HTRANS_SEQ      2'h3

`endif

// ==== logic/fault_hold_and_io_test.v ====
// Fault hold, I/O test override and serial test block with AHB-Lite registers
//
// Contract
// - A fault halts operation and holds description and code until cleared; a later fault event overwrites them.
// - Ordinary faults report code zero, service faults a nonzero code.
// - While faulted, start is ignored and stop is still honoured.
// - While test mode is on, start and stop are both ignored.
// - Overrides act only while no operation runs.
// - Test mode reports each general, trigger and strobe input level.
// - Test mode reports the recipe select bits as one unsigned number.
// - A forced true output is driven to its configured conduction level.
// - The recipe output number sets each bit, true at its polarity level.
// - Test mode repeats a test string on port 0 and shows its input.
// - Test mode repeats a test string on port 1 and shows its input.
//
// The register addresses and the AHB-Lite register port were decided locally.
`include "fault_io_map.vh"

module fault_hold_and_io_test #(
  parameter DESC_W = 8,
  parameter CODE_W = 16
) (
  input  wire              clock_i,
  input  wire              rst_i,
  // AHB-Lite slave
  input  wire              hsel_i,
  input  wire [7:0]        haddr_i,
  input  wire [1:0]        htrans_i,
  input  wire              hwrite_i,
  input  wire [2:0]        hsize_i,
  input  wire [31:0]       hwdata_i,
  input  wire              hready_i,
  output wire              hreadyout_o,
  output wire              hresp_o,
  output reg  [31:0]       hrdata_o,
  // Operation control
  input  wire              start_cmd_i,
  input  wire              stop_cmd_i,
  input  wire              op_done_i,
  output wire              op_run_o,
  output reg               stop_pulse_o,
  input  wire              fault_event_i,
  input  wire              fault_service_i,
  input  wire [DESC_W-1:0] fault_desc_i,
  input  wire [CODE_W-1:0] fault_code_i,
  output wire              fault_o,
  // Field inputs
  input  wire [3:0]        gen_in_i,
  input  wire              trigger_input_one_i,
  input  wire              trigger_input_two_i,
  input  wire              recipe_stb_in_i,
  input  wire [4:0]        recipe_in_i,
  // Normal function outputs and pins
  input  wire [12:0]       normal_out_i,
  output reg  [3:0]        gen_out_o,
  output reg  [1:0]        spare_out_o,
  output reg               recipe_stb_out_o,
  output reg  [4:0]        recipe_out_o,
  // Serial byte ports, index 0 point-to-point, 1 multidrop
  output wire [1:0]        tx_valid_o,
  input  wire [1:0]        tx_ready_i,
  output wire [15:0]       tx_data_o,
  input  wire [1:0]        rx_valid_i,
  input  wire [15:0]       rx_data_i,
  output wire              irq_o
);

  // --------------------------------------------------------------------
  // Operation state
  // --------------------------------------------------------------------
  localparam [2:0] ST_IDLE  = 3'h1;
  localparam [2:0] ST_RUN   = 3'h2;
  localparam [2:0] ST_FAULT = 3'h4;

  reg  [2:0]        state_reg;
  reg  [2:0]        state_next;
  reg               test_mode_reg;
  reg  [DESC_W-1:0] desc_reg;
  reg  [CODE_W-1:0] code_reg;
  reg  [12:0]       force_reg;
  reg  [12:0]       pol_reg;
  reg  [2:0]        irq_stat_reg;
  reg  [2:0]        irq_en_reg;
  reg  [7:0]        addr_reg;
  reg               wr_reg;
  wire              test_active;
  wire              fault_clear;
  wire              addr_phase;
  wire              wr_data_phase;
  wire              rx_read;
  wire [2:0]        irq_set;
  wire [2:0]        irq_clr;
  wire [1:0]        rx_full;
  wire [15:0]       rx_byte;

  // Test mode only takes hold while idle, so a running cycle is never upset
  assign test_active = test_mode_reg & state_reg[0];
  assign op_run_o = state_reg[1];
  assign fault_o = state_reg[2];

  always @* begin
    state_next = state_reg;
    case (state_reg)
      ST_IDLE: begin
        if (fault_event_i)
          state_next = ST_FAULT;
        else if (start_cmd_i && !test_mode_reg)
          state_next = ST_RUN;
      end
      ST_RUN: begin
        if (fault_event_i)
          state_next = ST_FAULT;
        else if (op_done_i || (stop_cmd_i && !test_mode_reg))
          state_next = ST_IDLE;
      end
      ST_FAULT: begin
        // Start is ignored here; only the clear leaves the fault
        if (fault_clear && !fault_event_i)
          state_next = ST_IDLE;
      end
      default: state_next = ST_IDLE;
    endcase
  end

  always @(posedge clock_i) begin
    if (rst_i) begin
      state_reg <= ST_IDLE;
      desc_reg <= {DESC_W{1'b0}};
      code_reg <= {CODE_W{1'b0}};
      stop_pulse_o <= 1'b0;
    end else begin
      state_reg <= state_next;
      // Stop is passed on in every state except test mode
      stop_pulse_o <= stop_cmd_i & ~test_mode_reg;
      if (fault_event_i) begin
        desc_reg <= fault_desc_i;
        code_reg <= fault_service_i ? fault_code_i
                                    : `ORDINARY_CODE;
      end
    end
  end

  // --------------------------------------------------------------------
  // Output override
  // --------------------------------------------------------------------
  // Polarity bit is the pin level that means true
  function [12:0] drive_level;
    input [12:0] truth;
    input [12:0] pol;
    begin
      drive_level = ~(truth ^ pol) & 13'h1fff;
    end
  endfunction

  wire [12:0] pin_next;
  assign pin_next = test_active ? drive_level(force_reg, pol_reg)
                                : normal_out_i;

  always @(posedge clock_i) begin
    if (rst_i) begin
      gen_out_o <= 4'h0;
      spare_out_o <= 2'h0;
      recipe_stb_out_o <= 1'b0;
      recipe_out_o <= 5'h00;
    end else begin
      gen_out_o <= pin_next[`OUT_GEN_LSB +: 4];
      spare_out_o <= pin_next[`OUT_SPARE_LSB +: 2];
      recipe_stb_out_o <= pin_next[`OUT_STB_BIT];
      recipe_out_o <= pin_next[`OUT_RCP_LSB +: 5];
    end
  end

  // --------------------------------------------------------------------
  // Serial test ports
  // --------------------------------------------------------------------
  function [7:0] test_char;
    input       port;
    input [2:0] idx;
    begin
      case (idx)
        3'h0: test_char = port ? 8'h34 : 8'h32;
        3'h1: test_char = port ? 8'h38 : 8'h33;
        3'h2: test_char = port ? 8'h35 : 8'h32;
        3'h3: test_char = 8'h20;
        3'h4: test_char = 8'h74;
        3'h5: test_char = 8'h65;
        3'h6: test_char = 8'h73;
        default: test_char = 8'h74;
      endcase
    end
  endfunction

  genvar p;
  generate
    for (p = 0; p < 2; p = p + 1) begin : serial
      reg [2:0] idx_reg;
      reg [7:0] tx_reg;
      reg [7:0] rx_reg;
      reg       full_reg;
      wire      take;
      wire [2:0] idx_inc;
      assign take = test_active & tx_ready_i[p];
      assign idx_inc = idx_reg + 3'h1;
      assign tx_valid_o[p] = test_active;
      assign tx_data_o[8*p +: 8] = tx_reg;
      assign rx_byte[8*p +: 8] = rx_reg;
      assign rx_full[p] = full_reg;
      assign irq_set[`IRQ_RX0_BIT + p] = test_active & rx_valid_i[p];
      always @(posedge clock_i) begin
        if (rst_i || !test_active) begin
          idx_reg <= 3'h0;
          tx_reg <= test_char(p == 1, 3'h0);
        end else if (take) begin
          // String wraps after its last character and repeats
          idx_reg <= idx_inc;
          tx_reg <= test_char(p == 1, idx_inc);
        end
      end
      always @(posedge clock_i) begin
        if (rst_i) begin
          rx_reg <= 8'h00;
          full_reg <= 1'b0;
        end else if (test_active && rx_valid_i[p]) begin
          // Newest character overwrites, as a live display would
          rx_reg <= rx_data_i[8*p +: 8];
          full_reg <= 1'b1;
        end else if (rx_read) begin
          full_reg <= 1'b0;
        end
      end
    end
  endgenerate

  // --------------------------------------------------------------------
  // Interrupts
  // --------------------------------------------------------------------
  assign irq_set[`IRQ_FAULT_BIT] = fault_event_i;
  assign irq_o = |(irq_stat_reg & irq_en_reg);

  always @(posedge clock_i) begin
    if (rst_i)
      irq_stat_reg <= 3'h0;
    else
      irq_stat_reg <= (irq_stat_reg & ~irq_clr) | irq_set;
  end

  // --------------------------------------------------------------------
  // AHB-Lite slave, zero wait states
  // --------------------------------------------------------------------
  wire [12:0] test_in;
  reg  [31:0] rd_value;

  assign addr_phase = hsel_i & hready_i & htrans_i[1];
  assign wr_data_phase = wr_reg;
  assign hreadyout_o = 1'b1;
  assign hresp_o = 1'b0;
  assign rx_read = addr_phase & ~hwrite_i & (haddr_i == `ADDR_RX_DATA);
  assign fault_clear = wr_data_phase & (addr_reg == `ADDR_CTRL) &
                       hwdata_i[`CTRL_CLEAR_BIT];
  assign irq_clr = (wr_data_phase && addr_reg == `ADDR_IRQ_CLR) ?
                   hwdata_i[2:0] : 3'h0;

  // Inputs read as zero outside test mode
  assign test_in = test_active ?
    {recipe_in_i, 1'b0, recipe_stb_in_i, trigger_input_two_i,
     trigger_input_one_i, gen_in_i} : 13'h0000;

  always @* begin
    case (haddr_i)
      `ADDR_CTRL:     rd_value = {31'h0, test_mode_reg};
      `ADDR_STATUS:   rd_value = {28'h0, test_active, test_mode_reg,
                                  state_reg[1], state_reg[2]};
      `ADDR_FLT_CODE: rd_value = {{(32-CODE_W){1'b0}}, code_reg};
      `ADDR_FLT_DESC: rd_value = {{(32-DESC_W){1'b0}}, desc_reg};
      `ADDR_TEST_IN:  rd_value = {19'h0, test_in};
      `ADDR_TEST_OUT: rd_value = {19'h0, force_reg};
      `ADDR_POLARITY: rd_value = {19'h0, pol_reg};
      `ADDR_RX_DATA:  rd_value = {7'h0, rx_full[1], rx_byte[15:8],
                                  7'h0, rx_full[0], rx_byte[7:0]};
      `ADDR_IRQ_STAT: rd_value = {29'h0, irq_stat_reg};
      `ADDR_IRQ_EN:   rd_value = {29'h0, irq_en_reg};
      default:        rd_value = 32'h0000_0000;
    endcase
  end

  always @(posedge clock_i) begin
    if (rst_i) begin
      addr_reg <= 8'h00;
      wr_reg <= 1'b0;
      hrdata_o <= 32'h0000_0000;
    end else begin
      if (hready_i) begin
        addr_reg <= haddr_i;
        wr_reg <= addr_phase & hwrite_i;
      end
      if (addr_phase && !hwrite_i)
        hrdata_o <= rd_value;
    end
  end

  always @(posedge clock_i) begin
    if (rst_i) begin
      test_mode_reg <= `CTRL_RESET;
      force_reg <= `TEST_OUT_RESET;
      pol_reg <= `POLARITY_RESET;
      irq_en_reg <= `IRQ_EN_RESET;
    end else if (wr_data_phase) begin
      case (addr_reg)
        `ADDR_CTRL:     test_mode_reg <= hwdata_i[`CTRL_TEST_BIT];
        `ADDR_TEST_OUT: force_reg <= hwdata_i[12:0] & 13'h1f7f;
        `ADDR_POLARITY: pol_reg <= hwdata_i[12:0] & 13'h1f7f;
        `ADDR_IRQ_EN:   irq_en_reg <= hwdata_i[2:0];
        default:        test_mode_reg <= test_mode_reg;
      endcase
    end
  end

  // Recipe strobe ordering is the controller's duty; inputs are only shown
  // here, never latched, so a strobe before its bits cannot corrupt state.

endmodule // fault_hold_and_io_test

// ==== bench/fault_checker.sv ====
// Port assertions for the fault hold and I/O test block
module fault_checker (
  input wire        clock_i,
  input wire        rst_i,
  input wire        hsel_i,
  input wire [7:0]  haddr_i,
  input wire [1:0]  htrans_i,
  input wire        hwrite_i,
  input wire [31:0] hwdata_i,
  input wire        start_cmd_i,
  input wire        stop_cmd_i,
  input wire        op_done_i,
  input wire        op_run_o,
  input wire        stop_pulse_o,
  input wire        fault_event_i,
  input wire        fault_o,
  input wire [12:0] normal_out_i,
  input wire [3:0]  gen_out_o,
  input wire [1:0]  spare_out_o,
  input wire        recipe_stb_out_o,
  input wire [4:0]  recipe_out_o,
  input wire [1:0]  tx_valid_o,
  input wire [1:0]  tx_ready_i,
  input wire [15:0] tx_data_o
);
  timeunit 1ns;
  timeprecision 1ps;
  // Shadow of the test bit, so no internal probe is needed
  logic wr_q;
  logic tst_q;
  wire act = tst_q && !op_run_o && !fault_o;
  wire [11:0] pins = {recipe_out_o, recipe_stb_out_o, spare_out_o, gen_out_o};
  wire [11:0] nrm = {normal_out_i[12:8], normal_out_i[6:0]};
  always @(posedge clock_i) begin
    if (rst_i) begin
      wr_q <= 1'h0;
      tst_q <= 1'h0;
    end else begin
      wr_q <= hsel_i && htrans_i[1] && hwrite_i && haddr_i == 8'h00;
      if (wr_q)
        tst_q <= hwdata_i[0];
    end
  end
  default clocking cb @(posedge clock_i);
  endclocking
  default disable iff (rst_i);
  a_fault_halt: assert property (
    fault_event_i |=> fault_o && !op_run_o) else $error("no halt");
  a_fault_hold: assert property (
    fault_o && !(wr_q && hwdata_i[1]) |=> fault_o) else $error("fault lost");
  a_fault_start: assert property (
    fault_o && start_cmd_i |=> !op_run_o) else $error("start in fault");
  a_fault_stop: assert property (
    fault_o && stop_cmd_i && !tst_q |=> stop_pulse_o) else $error("stop lost");
  a_test_stop: assert property (
    tst_q && stop_cmd_i |=> !stop_pulse_o) else $error("stop in test");
  a_test_start: assert property (
    act && start_cmd_i |=> !op_run_o) else $error("start in test");
  a_test_run: assert property (
    tst_q && op_run_o && !op_done_i && !fault_event_i |=> op_run_o)
    else $error("run ended in test");
  a_normal_pins: assert property (
    !act |=> pins == $past(nrm)) else $error("pins not normal");
  a_tx_valid: assert property (
    tx_valid_o == {act, act}) else $error("tx valid");
  a_tx_step: assert property (
    tx_valid_o[0] && tx_ready_i[0] ##1 tx_valid_o[0]
    |-> tx_data_o[7:0] != $past(tx_data_o[7:0])) else $error("tx stuck");
endmodule // fault_checker

bind fault_hold_and_io_test fault_checker chk_u (
  .clock_i(clock_i), .rst_i(rst_i), .hsel_i(hsel_i), .haddr_i(haddr_i),
  .htrans_i(htrans_i), .hwrite_i(hwrite_i), .hwdata_i(hwdata_i),
  .start_cmd_i(start_cmd_i), .stop_cmd_i(stop_cmd_i),
  .op_done_i(op_done_i), .op_run_o(op_run_o), .stop_pulse_o(stop_pulse_o),
  .fault_event_i(fault_event_i), .fault_o(fault_o),
  .normal_out_i(normal_out_i), .gen_out_o(gen_out_o),
  .spare_out_o(spare_out_o), .recipe_stb_out_o(recipe_stb_out_o),
  .recipe_out_o(recipe_out_o), .tx_valid_o(tx_valid_o),
  .tx_ready_i(tx_ready_i), .tx_data_o(tx_data_o));

// ==== bench/serial_partner.sv ====
// Far side of both serial byte ports
module serial_partner (
  input  logic        clock_i,
  input  logic [1:0]  send_i,
  input  logic [15:0] byte_i,
  output logic [1:0]  tx_ready_o,
  output logic [1:0]  rx_valid_o,
  output logic [15:0] rx_data_o
);
  timeunit 1ns;
  timeprecision 1ps;
  integer seed = 86;
  initial begin
    tx_ready_o = 2'h0;
    rx_valid_o = 2'h0;
    rx_data_o = 16'h0000;
  end
  // Random stalls; idle data inverted so a stale byte never looks valid
  always @(posedge clock_i) begin
    tx_ready_o <= 2'($random(seed));
    rx_valid_o <= send_i;
    rx_data_o <= send_i != 2'h0 ? byte_i : ~rx_data_o;
  end
endmodule // serial_partner

// ==== bench/tb_fault_hold_and_io_test.sv ====
// Self-checking bench for the fault hold and I/O test block
module tb_fault_hold_and_io_test;
  timeunit 1ns;
  timeprecision 1ps;
  logic clock_i = 0;
  logic rst_i = 1;
  logic hsel = 0, hwr = 0, start = 0, stop = 0, done = 0, fev = 0, fsv = 0;
  logic stb = 0, tg1 = 0, tg2 = 0, rdp = 0;
  logic [1:0] htr = 0, send = 0;
  logic [3:0] gin = 0;
  logic [4:0] rcp = 0;
  logic [7:0] ha = 0, desc = 0;
  logic [12:0] nrm = 0, t, p;
  logic [15:0] code = 0, rxb = 0;
  logic [31:0] hwd = 0;
  logic [63:0] q, expq[$];
  logic [63:0] str[2] = '{"232 test", "485 test"};
  wire hro, hrsp, irq, run, spl, flt, rstb;
  wire [1:0] sout, txv, rdy, rxv;
  wire [3:0] gout;
  wire [4:0] rout;
  wire [15:0] txd, rxd;
  wire [31:0] hrd;
  integer seed = 86, num_errors = 0, compares = 0, cyc = 0, i, k;
  integer pix[2] = '{0, 0};
  always #5 clock_i = ~clock_i;
  fault_hold_and_io_test dut_u (
    .clock_i(clock_i), .rst_i(rst_i), .hsel_i(hsel), .haddr_i(ha),
    .htrans_i(htr), .hwrite_i(hwr), .hsize_i(3'h2), .hwdata_i(hwd),
    .hready_i(hro), .hreadyout_o(hro), .hresp_o(hrsp), .hrdata_o(hrd),
    .start_cmd_i(start), .stop_cmd_i(stop), .op_done_i(done),
    .op_run_o(run), .stop_pulse_o(spl), .fault_event_i(fev),
    .fault_service_i(fsv), .fault_desc_i(desc), .fault_code_i(code),
    .fault_o(flt), .gen_in_i(gin), .trigger_input_one_i(tg1),
    .trigger_input_two_i(tg2), .recipe_stb_in_i(stb), .recipe_in_i(rcp),
    .normal_out_i(nrm), .gen_out_o(gout), .spare_out_o(sout),
    .recipe_stb_out_o(rstb), .recipe_out_o(rout), .tx_valid_o(txv),
    .tx_ready_i(rdy), .tx_data_o(txd), .rx_valid_i(rxv), .rx_data_i(rxd),
    .irq_o(irq));
  serial_partner far_u (.clock_i(clock_i), .send_i(send), .byte_i(rxb),
    .tx_ready_o(rdy), .rx_valid_o(rxv), .rx_data_o(rxd));
  task fail(input string m);
    num_errors++;
    $display("MISMATCH at %0t: %s", $time, m);
  endtask
  task chk(input [31:0] g, e);
    compares++;
    if (g !== e)
      fail("port value");
  endtask
  // Reads note their masked expectation for the monitor below
  task bus(input w, input [7:0] a, input [31:0] d, m);
    hsel <= 1;
    htr <= 2'h2;
    hwr <= w;
    ha <= a;
    @(posedge clock_i);
    while (hro !== 1'h1) @(posedge clock_i);
    htr <= 2'h0;
    hwd <= d;
    if (!w)
      expq.push_back({m, d & m});
    @(posedge clock_i);
    while (hro !== 1'h1) @(posedge clock_i);
  endtask
  task pins(input [12:0] e);
    chk({rout, 1'h0, rstb, sout, gout}, e & 13'h1f7f);
  endtask
  task print_verdict;
    $display("Compares %0d, mismatches %0d", compares, num_errors);
    if (num_errors == 0 && compares > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  // Timeout well above the 150 or so cycles the sequence needs
  always @(posedge clock_i) begin
    cyc <= cyc + 1;
    if (rdp) begin
      q = expq.pop_front();
      compares++;
      if ((hrd & q[63:32]) !== q[31:0])
        fail("read data");
      compares++;
      if (hrsp !== 1'h0)
        fail("bus response");
    end
    rdp <= hsel && htr[1] && !hwr;
    for (k = 0; k < 2; k++) begin
      if (txv[k] && rdy[k]) begin
        compares++;
        if (txd[8*k+:8] !== str[k][63-8*pix[k]-:8])
          fail("tx byte");
        pix[k] = (pix[k] + 1) % 8;
      end else if (!txv[k])
        pix[k] = 0;
    end
    if (cyc == 3000) begin
      num_errors++;
      print_verdict;
    end
  end
  initial begin
    repeat (16) @(posedge clock_i);
    rst_i <= 0;
    nrm <= $random(seed);
    bus(0, 8'h04, 0, 32'hf);
    bus(0, 8'h18, 32'h1fff, 32'h1fff);
    bus(0, 8'h28, 0, 32'h7);
    bus(0, 8'h3c, 0, 32'hffffffff);
    $display("reset values done");
    start <= 1;
    @(posedge clock_i);
    start <= 0;
    desc <= $random(seed);
    fev <= 1;
    @(posedge clock_i);
    fev <= 0;
    chk(run, 1);
    bus(0, 8'h0c, desc, 32'hff);
    bus(0, 8'h08, 0, 32'hffff);
    chk(irq, 0);
    bus(1, 8'h28, 7, 0);
    start <= 1;
    stop <= 1;
    @(posedge clock_i);
    start <= 0;
    stop <= 0;
    chk(irq, 1);
    @(posedge clock_i);
    chk(spl, 1);
    chk(run, 0);
    chk(flt, 1);
    bus(1, 8'h24, 1, 0);
    bus(1, 8'h00, 2, 0);
    @(posedge clock_i);
    chk(irq, 0);
    chk(flt, 0);
    code <= $random(seed);
    fsv <= 1;
    fev <= 1;
    @(posedge clock_i);
    fev <= 0;
    bus(0, 8'h08, code, 32'hffff);
    fsv <= 0;
    bus(1, 8'h00, 2, 0);
    $display("fault tests done");
    start <= 1;
    @(posedge clock_i);
    start <= 0;
    bus(1, 8'h14, $random(seed), 0);
    bus(1, 8'h00, 1, 0);
    stop <= 1;
    @(posedge clock_i);
    stop <= 0;
    @(posedge clock_i);
    chk(run, 1);
    chk(spl, 0);
    pins(nrm);
    done <= 1;
    @(posedge clock_i);
    done <= 0;
    for (i = 0; i < 6; i++) begin
      t = i == 0 ? 13'h0 : i == 1 ? 13'h1f7f : $random(seed);
      p = $random(seed);
      bus(1, 8'h18, p, 0);
      bus(1, 8'h14, t, 0);
      {gin, tg1, tg2, rcp} <= $random(seed);
      start <= 1;
      @(posedge clock_i);
      start <= 0;
      stb <= $random(seed);
      @(posedge clock_i);
      pins(~(t ^ p));
      chk(run, 0);
      bus(0, 8'h10, {rcp, 1'h0, stb, tg2, tg1, gin}, 32'h1f7f);
    end
    $display("override tests done");
    rxb <= $random(seed);
    send <= 2'h3;
    @(posedge clock_i);
    send <= 2'h0;
    repeat (30) @(posedge clock_i);
    bus(0, 8'h20, 7, 7);
    bus(0, 8'h1c, {7'h0, 1'h1, rxb[15:8], 7'h0, 1'h1, rxb[7:0]},
      32'h1ff01ff);
    bus(0, 8'h1c, 0, 32'h1000100);
    bus(1, 8'h24, 7, 0);
    @(posedge clock_i);
    chk(irq, 0);
    $display("serial tests done");
    bus(1, 8'h00, 0, 0);
    repeat (2) @(posedge clock_i);
    pins(nrm);
    bus(0, 8'h10, 0, 32'h1f7f);
    $display("leave test done");
    print_verdict;
  end
endmodule // tb_fault_hold_and_io_test
